// ### csrc_core.sv
// command status recorder and remote control word interpreter
// Functional notes
// - one status word per command-list entry, stored in the error memory
// - extended status in low byte, primary status in high byte
// - local link failures coded 0x0100 to 0x0800 in 0x0100 steps
// - remote failures use the upper nibble 0x1000 to 0xc000
// - primary byte 0xf0 means low byte is the extended code
// - extended codes 0xf001 to 0xf01f, 0xf01c and 0xf01d reserved
// - module-specific negative codes come only from this block
// - 0xffff for missing cts, 0xfffe for transmit timeout
// - 0xfff6 for ack timeout, 0xfff5 for response timeout
// - 0xfff4 when reply byte count mismatches the request
// - 0xffec nak received, 0xffeb nak sent
// - remote writes control word; 9998 warm boot, 9999 cold boot
// - 9997 uploads configuration to host, then warm boots
// - control word cleared after a 9998 or 9999 boot; upload request not cleared
// - upload result written into control word: 0, -1, -2, -3, -12
`include "csrc_map.svh"
module csrc_core #(
   parameter int N_CMD = 100
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // completion report from the link engine
   input  wire logic                  i_done,
   input  wire logic [$clog2(N_CMD)-1:0] i_done_idx,
   input  wire csrc_pkg::csrc_fault_t i_done_fault,
   input  wire logic                  i_done_slave,
   input  wire logic [7:0]            i_done_prim,
   input  wire logic [7:0]            i_done_ext,
   // status word readback
   input  wire logic [$clog2(N_CMD)-1:0] i_rd_idx,
   output logic      [15:0]           o_rd_status,
   // remote control word access
   input  wire logic                  i_ctl_wr,
   input  wire logic [15:0]           i_ctl_addr,
   input  wire logic [15:0]           i_ctl_wdata,
   output logic      [15:0]           o_ctl_word,
   // host upload handshake
   output logic                       o_upload_req,
   input  wire logic                  i_upload_done,
   input  wire csrc_pkg::csrc_upres_t i_upload_res,
   input  wire logic                  i_upload_len_err,
   // boot outputs
   output logic                       o_warm_boot,
   output logic                       o_cold_boot
);

   // ***********************************
   // status word composition
   // ***********************************
   logic [15:0] status_nxt;
   logic [15:0] slave_word;

   always_comb
   begin
      slave_word = `CSRC_OK;
      if (i_done_prim == `CSRC_EXT_PRIMARY)
      begin
         if (i_done_ext >= `CSRC_EXT_MIN && i_done_ext <= `CSRC_EXT_MAX
             && i_done_ext != `CSRC_EXT_RSV0 && i_done_ext != `CSRC_EXT_RSV1)
            slave_word = {i_done_prim, i_done_ext};
         else
            slave_word = {i_done_prim, `CSRC_EXT_MAX};
      end
      else if (i_done_prim[3:0] != 4'h0 && i_done_prim[7:4] == 4'h0
               && i_done_prim <= `CSRC_LOC_MAX)
         slave_word = {i_done_prim, 8'h00};
      else if (i_done_prim[3:0] == 4'h0 && i_done_prim[7:4] != 4'h0
               && i_done_prim[7:4] <= `CSRC_REM_MAX)
         slave_word = {i_done_prim, 8'h00};
      else
         slave_word = `CSRC_OK;
   end

   always_comb
   begin
      case (i_done_fault)
         csrc_pkg::CSRC_FLT_CTS:     status_nxt = `CSRC_M_CTS;
         csrc_pkg::CSRC_FLT_TX_TMO:  status_nxt = `CSRC_M_TX_TMO;
         csrc_pkg::CSRC_FLT_ACK_TMO: status_nxt = `CSRC_M_ACK_TMO;
         csrc_pkg::CSRC_FLT_RSP_TMO: status_nxt = `CSRC_M_RSP_TMO;
         csrc_pkg::CSRC_FLT_LEN:     status_nxt = `CSRC_M_LEN;
         csrc_pkg::CSRC_FLT_NAK_RX:  status_nxt = `CSRC_M_NAK_RX;
         csrc_pkg::CSRC_FLT_NAK_TX:  status_nxt = `CSRC_M_NAK_TX;
         // slave codes never carry module-specific values
         csrc_pkg::CSRC_FLT_NONE:    status_nxt = i_done_slave ? slave_word : `CSRC_OK;
         default:                    status_nxt = `CSRC_OK;
      endcase
   end

   // ***********************************
   // command error memory
   // ***********************************
   logic [15:0] status_mem [N_CMD];

   always_ff @(posedge i_clk)
   begin
      if (i_done && 32'(i_done_idx) < N_CMD)
         status_mem[i_done_idx] <= status_nxt;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_rd_status <= `CSRC_OK;
      else if (32'(i_rd_idx) < N_CMD)
         o_rd_status <= status_mem[i_rd_idx];
      else
         o_rd_status <= `CSRC_OK;
   end

   // ***********************************
   // remote control word
   // ***********************************
   logic ctl_hit;
   logic upload_r;
   logic warm_r;
   logic cold_r;
   logic upwarm_r;

   assign ctl_hit = i_ctl_wr && i_ctl_addr == `CSRC_CTRL_OFFSET;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_ctl_word <= `CSRC_CTRL_RESET;
      else if (ctl_hit)
         o_ctl_word <= i_ctl_wdata;
      else if (upload_r && i_upload_done)
      begin
         if (i_upload_len_err)
            o_ctl_word <= `CSRC_UP_LEN_ERR;
         else
         begin
            case (i_upload_res)
               csrc_pkg::CSRC_UPR_OK:  o_ctl_word <= `CSRC_UP_OK;
               csrc_pkg::CSRC_UPR_GEN: o_ctl_word <= `CSRC_UP_GEN_ERR;
               csrc_pkg::CSRC_UPR_P1:  o_ctl_word <= `CSRC_UP_P1_ERR;
               csrc_pkg::CSRC_UPR_P2:  o_ctl_word <= `CSRC_UP_P2_ERR;
               default:                o_ctl_word <= `CSRC_UP_GEN_ERR;
            endcase
         end
      end
      else if (warm_r && !upload_r && !upwarm_r)
         o_ctl_word <= `CSRC_CTRL_RESET;
      else if (cold_r)
         o_ctl_word <= `CSRC_CTRL_RESET;
   end

   // upload request held until the host answers
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         upload_r <= 1'b0;
      else if (ctl_hit && i_ctl_wdata == `CSRC_REQ_UPLOAD)
         upload_r <= 1'b1;
      else if (i_upload_done)
         upload_r <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         warm_r <= 1'b0;
      else if (ctl_hit)
         warm_r <= i_ctl_wdata == `CSRC_REQ_WARM;
      else if (upload_r && i_upload_done)
         warm_r <= 1'b1;
      else
         warm_r <= 1'b0;
   end

   // warm boot that follows an upload keeps the upload result
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         upwarm_r <= 1'b0;
      else
         upwarm_r <= !ctl_hit && upload_r && i_upload_done;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         cold_r <= 1'b0;
      else
         cold_r <= ctl_hit && i_ctl_wdata == `CSRC_REQ_COLD;
   end

   assign o_upload_req = upload_r;
   assign o_warm_boot  = warm_r && !upload_r;
   assign o_cold_boot  = cold_r;

endmodule : csrc_core

// ### csrc_map.svh
// register offsets, status codes and control values for the command status block
`ifndef CSRC_MAP_SVH
`define CSRC_MAP_SVH
`define CSRC_CTRL_OFFSET  16'h1e78
`define CSRC_CTRL_RESET   16'h0000
`define CSRC_REQ_UPLOAD   16'h270d
`define CSRC_REQ_WARM     16'h270e
`define CSRC_REQ_COLD     16'h270f
`define CSRC_UP_OK        16'h0000
`define CSRC_UP_GEN_ERR   16'hffff
`define CSRC_UP_P1_ERR    16'hfffe
`define CSRC_UP_P2_ERR    16'hfffd
`define CSRC_UP_LEN_ERR   16'hfff4
`define CSRC_OK           16'h0000
`define CSRC_EXT_PRIMARY  8'hf0
`define CSRC_EXT_MIN      8'h01
`define CSRC_EXT_MAX      8'h1f
`define CSRC_EXT_RSV0     8'h1c
`define CSRC_EXT_RSV1     8'h1d
`define CSRC_LOC_MAX      8'h08
`define CSRC_REM_MAX      4'hc
`define CSRC_M_CTS        16'hffff
`define CSRC_M_TX_TMO     16'hfffe
`define CSRC_M_ACK_TMO    16'hfff6
`define CSRC_M_RSP_TMO    16'hfff5
`define CSRC_M_LEN        16'hfff4
`define CSRC_M_NAK_RX     16'hffec
`define CSRC_M_NAK_TX     16'hffeb
`endif

// ### csrc_pkg.sv
// types for the command status and remote control block
package csrc_pkg;
   typedef enum logic [2:0] {
      CSRC_FLT_NONE,
      CSRC_FLT_CTS,
      CSRC_FLT_TX_TMO,
      CSRC_FLT_ACK_TMO,
      CSRC_FLT_RSP_TMO,
      CSRC_FLT_LEN,
      CSRC_FLT_NAK_RX,
      CSRC_FLT_NAK_TX
   } csrc_fault_t;
   typedef enum logic [1:0] {
      CSRC_UPR_OK,
      CSRC_UPR_GEN,
      CSRC_UPR_P1,
      CSRC_UPR_P2
   } csrc_upres_t;
endpackage : csrc_pkg

// ### csrc_core_props.sv
// checker for the control word and boot outputs
module csrc_core_props (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_ctl_wr,
   input wire logic [15:0] i_ctl_addr,
   input wire logic [15:0] i_ctl_wdata,
   input wire logic [15:0] o_ctl_word,
   input wire logic        o_upload_req,
   input wire logic        i_upload_done,
   input wire logic        o_warm_boot,
   input wire logic        o_cold_boot
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic w, wu, ww, wc, fin;
   assign w   = i_ctl_wr && i_ctl_addr == 16'h1e78;
   assign wu  = w && i_ctl_wdata == 16'h270d;
   assign ww  = w && i_ctl_wdata == 16'h270e;
   assign wc  = w && i_ctl_wdata == 16'h270f;
   assign fin = o_upload_req && i_upload_done;
   a_cold_boot: assert property (wc ##1 !w |-> o_cold_boot && o_ctl_word == 16'h270f ##1 o_ctl_word == 16'h0)
      else $error("cold boot");
   a_warm_boot: assert property (ww ##1 !w |-> o_warm_boot && !o_cold_boot ##1 o_ctl_word == 16'h0)
      else $error("warm boot");
   a_warm_cause: assert property (o_warm_boot |-> $past(ww) || $past(fin))
      else $error("warm cause");
   a_upload_start: assert property (wu |=> o_upload_req && o_ctl_word == 16'h270d && !o_warm_boot)
      else $error("upload start");
   a_upload_hold: assert property (o_upload_req && !i_upload_done |=> o_upload_req)
      else $error("upload hold");
   a_upload_end: assert property (fin && !w |=> !o_upload_req && o_warm_boot ##1 !o_warm_boot)
      else $error("upload end");
   a_other_kept: assert property (w && !(i_ctl_wdata inside {[16'h270d:16'h270f]}) && !i_upload_done
      |=> o_ctl_word == $past(i_ctl_wdata) && !o_warm_boot && !o_cold_boot)
      else $error("other value");
   a_addr_ignored: assert property (i_ctl_wr && !w && !o_warm_boot && !o_cold_boot && !i_upload_done
      |=> $stable(o_ctl_word))
      else $error("foreign address");
endmodule : csrc_core_props

// ### csrc_host_model.sv
// host side model that services the upload
module csrc_host_model (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_upload_req,
   input  wire logic [3:0]       i_wait,
   input  wire logic [2:0]       i_res,
   output logic                  o_done,
   output csrc_pkg::csrc_upres_t o_res,
   output logic                  o_len_err
);
   logic [3:0] cnt_r;
   logic       tgl_r;
   always_ff @(posedge i_clk)
   begin
      tgl_r <= i_rst ? 1'b0 : ~tgl_r;
      o_done <= 1'b0;
      // result lines wander outside the answer
      o_res <= csrc_pkg::csrc_upres_t'({tgl_r, ~tgl_r});
      o_len_err <= tgl_r;
      cnt_r <= cnt_r + 4'h1;
      if (i_rst || !i_upload_req || o_done)
         cnt_r <= 4'h0;
      else if (cnt_r == i_wait)
      begin
         o_done <= 1'b1;
         o_res <= csrc_pkg::csrc_upres_t'(i_res[1:0]);
         o_len_err <= i_res[2];
      end
   end
endmodule : csrc_host_model

// ### csrc_core_tb.sv
// self-checking bench for the command status block
bind csrc_core csrc_core_props i_csrc_core_props (.i_clk, .i_rst, .i_ctl_wr, .i_ctl_addr, .i_ctl_wdata,
   .o_ctl_word, .o_upload_req, .i_upload_done, .o_warm_boot, .o_cold_boot);
module csrc_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_rst = 1, i_done = 0, i_done_slave = 0, i_ctl_wr = 0, obs_v = 0, obs_sel = 1;
   logic o_upload_req, o_warm_boot, o_cold_boot, up_done, up_len;
   logic [4:0] i_done_idx = 0, i_rd_idx = 0;
   logic [7:0] i_done_prim = 0, i_done_ext = 0;
   logic [15:0] i_ctl_addr = 16'h1e78, i_ctl_wdata = 0, o_rd_status, o_ctl_word, ev [32];
   logic [15:0] up_tab [5] = '{16'h0000, 16'hffff, 16'hfffe, 16'hfffd, 16'hfff4};
   logic [3:0] h_wait = 0;
   logic [2:0] h_res = 0;
   logic [31:0] rs = 5159;
   logic [17:0] exp_q [$];
   int fail_count = 0, samples_checked = 0;
   csrc_pkg::csrc_fault_t i_done_fault = csrc_pkg::CSRC_FLT_NONE;
   csrc_pkg::csrc_upres_t up_res;
   csrc_core #(.N_CMD(32)) i_csrc_core (.i_clk, .i_rst, .i_done, .i_done_idx, .i_done_fault, .i_done_slave,
      .i_done_prim, .i_done_ext, .i_rd_idx, .o_rd_status, .i_ctl_wr, .i_ctl_addr, .i_ctl_wdata, .o_ctl_word,
      .o_upload_req, .i_upload_done(up_done), .i_upload_res(up_res), .i_upload_len_err(up_len), .o_warm_boot,
      .o_cold_boot);
   csrc_host_model i_csrc_host_model (.i_clk, .i_rst, .i_upload_req(o_upload_req), .i_wait(h_wait),
      .i_res(h_res), .o_done(up_done), .o_res(up_res), .o_len_err(up_len));
   always #25 i_clk = ~i_clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   function automatic logic [15:0] want(input int f, input logic s, input logic [7:0] p, x);
      logic [15:0] m [8] = '{16'h0, 16'hffff, 16'hfffe, 16'hfff6, 16'hfff5, 16'hfff4, 16'hffec, 16'hffeb};
      if (f != 0) return m[f];
      if (!s) return 16'h0;
      if (p inside {[8'h01:8'h08]} || p[3:0] == 0 && p inside {[8'h10:8'hc0]}) return {p, 8'h00};
      if (p == 8'hf0) return {p, x inside {[8'h01:8'h1b], 8'h1e, 8'h1f} ? x : 8'h1f};
      return 16'h0;
   endfunction : want
   task automatic chk(input logic [17:0] e, s);
      samples_checked++;
      if (s !== e) begin fail_count++; $display("wrong value boot pulses and word expected %h seen %h", e, s); end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic cyc(input logic wr, input logic [15:0] d, input logic c, input logic [17:0] e);
      i_ctl_wr = wr;
      i_ctl_wdata = d;
      obs_v = c;
      if (c) exp_q.push_back(e);
      @(negedge i_clk);
   endtask : cyc
   always @(posedge i_clk)
      if (obs_v) chk(exp_q.pop_front(), {o_warm_boot, o_cold_boot, obs_sel ? o_ctl_word : o_rd_status});
   initial
   begin
      repeat (10) @(negedge i_clk);
      i_rst = 0;
      for (int k = 0; k < 2; k++)
      begin
         cyc(1, 16'(16'h270e + k), 0, 0);
         cyc(0, 0, 1, {~k[0], k[0], 16'(16'h270e + k)});
         cyc(0, 0, 1, 18'h0);
      end
      rs = xs(rs);
      cyc(1, 16'h270f, 0, 0);
      cyc(1, {4'h0, rs[11:0]}, 1, {2'b01, 16'h270f});
      i_ctl_addr = 16'h1e79;
      cyc(1, 16'h270f, 1, {6'h00, rs[11:0]});
      i_ctl_addr = 16'h1e78;
      cyc(0, 0, 1, {6'h00, rs[11:0]});
      for (int r = 0; r < 5; r++)
      begin
         rs = xs(rs);
         h_wait = rs[3:0];
         h_res = 3'(r);
         cyc(1, 16'h270d, 0, 0);
         cyc(0, 0, 1, {2'b00, 16'h270d});
         for (int t = 0; o_warm_boot !== 1'b1; t++)
         begin
            if (t > 40) begin fail_count++; end_sim(); end
            cyc(0, 0, 0, 0);
         end
         cyc(0, 0, 1, {2'b10, up_tab[r]});
         cyc(0, 0, 1, {2'b00, up_tab[r]});
      end
      for (int i = 0; i < 33; i++)
      begin
         rs = xs(rs);
         i_done = i < 32;
         i_done_idx = 5'(i);
         i_done_fault = csrc_pkg::csrc_fault_t'(i < 8 ? i : 0);
         i_done_slave = i > 7 && i < 31;
         i_done_prim = rs[5] ? 8'hf0 : rs[4] ? {rs[3:0], 4'h0} : {4'h0, rs[3:0]};
         i_done_ext = rs[5] ? {2'b00, rs[13:8]} : 8'h00;
         ev[5'(i)] = want(i < 8 ? i : 0, i_done_slave, i_done_prim, i_done_ext);
         cyc(0, 0, 0, 0);
      end
      obs_sel = 0;
      for (int i = 0; i < 33; i++)
      begin
         i_rd_idx = 5'(i);
         cyc(0, 0, i > 0, {2'b00, ev[5'(i - 1)]});
      end
      end_sim();
   end
endmodule : csrc_core_tb
